// >>> core/sfdp_map.svh
// constants for the discovery parameter table responder
// assumes inclusion by core/sfdp_parameter_read.sv only
`ifndef SFDP_MAP_SVH
`define SFDP_MAP_SVH

// -----------------------------------------------------------------
// command, address and dummy phase
// -----------------------------------------------------------------
`define SFDP_CMD_CODE 8'h5A
`define SFDP_CMD_BITS 5'h08
`define SFDP_ADDR_BITS 5'h18
`define SFDP_DUMMY_STD 5'h08
`define SFDP_DUMMY_QUAD 5'h0A

// -----------------------------------------------------------------
// table space
// -----------------------------------------------------------------
`define SFDP_PTR_W 11
`define SFDP_PTR_LAST 11'h7FF
`define SFDP_FILL 8'hFF
`define SFDP_FIFO_DEPTH 8

`endif

// >>> core/sfdp_pkg.sv
// types shared by the discovery parameter table responder
// assumes nothing beyond a SystemVerilog compiler
package sfdp_pkg;

    // transfer state of one chip select frame
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101
    } state_e;

    // active bus protocol
    typedef enum logic [1:0] {
        PR_EXT = 2'b00,
        PR_DUAL = 2'b01,
        PR_QUAD = 2'b10
    } proto_e;

    // drive of the four serial data lines
    typedef struct packed {
        logic [3:0] value;
        logic [3:0] oe;
    } drive_s;

endpackage

// >>> core/sfdp_parameter_read.sv
// discovery parameter table read responder, with its byte fifo
// assumes the serial pins are asynchronous to I_CLK and that the
// serial clock is much slower than I_CLK (at least 8 clocks a phase)
`timescale 1ns/1ns
`include "sfdp_map.svh"


// -----------------------------------------------------------------
// byte fifo between table lookup and output shifter
// -----------------------------------------------------------------
module sfdp_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers; flush drops everything in one clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// -----------------------------------------------------------------
// responder top
// -----------------------------------------------------------------
module sfdp_parameter_read #(
    parameter logic [7:0] CMD_CODE = `SFDP_CMD_CODE,
    parameter int FIFO_DEPTH = `SFDP_FIFO_DEPTH
) (
    // system clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // serial pins
    input wire logic I_SCK,
    input wire logic I_CS_N,
    input wire logic [3:0] I_DQ,
    output sfdp_pkg::drive_s O_DQ,
    // device state, same clock domain
    input wire sfdp_pkg::proto_e I_PROTO,
    input wire logic I_WRITE_BUSY,
    output logic O_ACTIVE
);
    sfdp_pkg::state_e st_reg;
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic sck_d_reg;
    logic rise;
    logic fall;
    logic cs_n;
    logic [3:0] dq_s;
    logic [4:0] cnt_reg;
    logic [23:0] addr_reg;
    logic [23:0] addr_next;
    logic [7:0] cmd_next;
    logic [7:0] sh_reg;
    logic [`SFDP_PTR_W-1:0] ptr_reg;
    logic fetch_reg;
    sfdp_pkg::drive_s drv_reg;
    logic [7:0] rom_byte;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic pop;
    logic [7:0] byte_now;
    logic addr_done;

    // table contents; a lookup, so literal bytes stand here
    function automatic logic [7:0] table_byte(input logic [`SFDP_PTR_W-1:0] a);
        case (a)
            11'h000: table_byte = 8'h53;
            11'h001: table_byte = 8'h46;
            11'h002: table_byte = 8'h44;
            11'h003: table_byte = 8'h50;
            11'h004: table_byte = 8'h00;
            11'h005: table_byte = 8'h01;
            11'h006: table_byte = 8'h00;
            11'h008: table_byte = 8'h00;
            11'h009: table_byte = 8'h00;
            11'h00A: table_byte = 8'h01;
            11'h00B: table_byte = 8'h09;
            11'h00C: table_byte = 8'h30;
            11'h00D: table_byte = 8'h00;
            11'h00E: table_byte = 8'h00;
            11'h030: table_byte = 8'hE5;
            11'h031: table_byte = 8'h20;
            11'h032: table_byte = 8'hF1;
            11'h037: table_byte = 8'h03;
            11'h038: table_byte = 8'h29;
            11'h039: table_byte = 8'hEB;
            11'h03A: table_byte = 8'h27;
            11'h03B: table_byte = 8'h6B;
            11'h03C: table_byte = 8'h08;
            11'h03D: table_byte = 8'h3B;
            11'h03E: table_byte = 8'h27;
            11'h03F: table_byte = 8'hBB;
            11'h040: table_byte = 8'hFF;
            11'h046: table_byte = 8'h27;
            11'h047: table_byte = 8'hBB;
            11'h04A: table_byte = 8'h29;
            11'h04B: table_byte = 8'hEB;
            11'h04C: table_byte = 8'h0C;
            11'h04D: table_byte = 8'h20;
            11'h04E: table_byte = 8'h10;
            11'h04F: table_byte = 8'hD8;
            11'h050, 11'h051, 11'h052, 11'h053: table_byte = 8'h00;
            // 07h, 0Fh, 10h-2Fh, 33h-36h, 41h-45h, 48h-49h, above 53h
            default: table_byte = `SFDP_FILL;
        endcase
    endfunction

    // address lanes per protocol
    function automatic logic [2:0] addr_lanes(input sfdp_pkg::proto_e p);
        case (p)
            sfdp_pkg::PR_DUAL: addr_lanes = 3'h2;
            sfdp_pkg::PR_QUAD: addr_lanes = 3'h4;
            default: addr_lanes = 3'h1;
        endcase
    endfunction

    // top bits of a byte placed on the output lanes
    function automatic logic [3:0] out_bits(input sfdp_pkg::proto_e p, input logic [7:0] v);
        case (p)
            sfdp_pkg::PR_DUAL: out_bits = {2'h0, v[7:6]};
            sfdp_pkg::PR_QUAD: out_bits = v[7:4];
            default: out_bits = {2'h0, v[7], 1'b0};
        endcase
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers and clock edge detection
    // -----------------------------------------------------------------
    // second stage alone feeds logic; reset matches idle pins, so no false edge
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sync1_reg <= 6'h2F;
            sync2_reg <= 6'h2F;
            sck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {I_CS_N, I_SCK, I_DQ};
            sync2_reg <= sync1_reg;
            sck_d_reg <= sync2_reg[4];
        end
    end

    assign cs_n = sync2_reg[5];
    assign dq_s = sync2_reg[3:0];
    assign rise = !cs_n && sync2_reg[4] && !sck_d_reg;
    assign fall = !cs_n && !sync2_reg[4] && sck_d_reg;

    // -----------------------------------------------------------------
    // phase sequencing
    // -----------------------------------------------------------------
    // command always enters on line zero, address on the protocol lanes
    always_comb begin
        cmd_next = {addr_reg[6:0], dq_s[0]};
        case (I_PROTO)
            sfdp_pkg::PR_DUAL: addr_next = {addr_reg[21:0], dq_s[1:0]};
            sfdp_pkg::PR_QUAD: addr_next = {addr_reg[19:0], dq_s};
            default: addr_next = {addr_reg[22:0], dq_s[0]};
        endcase
    end

    // counts address bits, one lane group per clock; the last address group ends the phase
    assign addr_done = (st_reg == sfdp_pkg::ST_ADDR) && rise &&
        (5'(cnt_reg + 5'(addr_lanes(I_PROTO))) == `SFDP_ADDR_BITS);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_reg <= sfdp_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
            addr_reg <= 24'h000000;
        end else if (cs_n) begin
            st_reg <= sfdp_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
        end else begin
            case (st_reg)
                sfdp_pkg::ST_IDLE: begin
                    st_reg <= sfdp_pkg::ST_CMD;
                    cnt_reg <= 5'h00;
                end
                sfdp_pkg::ST_CMD: begin
                    if (rise) begin
                        addr_reg <= {16'h0000, cmd_next};
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == `SFDP_CMD_BITS - 5'h01) begin
                            cnt_reg <= 5'h00;
                            // a busy device leaves the command undecoded
                            if (cmd_next == CMD_CODE && !I_WRITE_BUSY) begin
                                st_reg <= sfdp_pkg::ST_ADDR;
                            end else begin
                                st_reg <= sfdp_pkg::ST_IGNORE;
                            end
                        end
                    end
                end
                sfdp_pkg::ST_ADDR: begin
                    if (rise) begin
                        addr_reg <= addr_next;
                        cnt_reg <= 5'(cnt_reg + 5'(addr_lanes(I_PROTO)));
                        if (addr_done) begin
                            st_reg <= sfdp_pkg::ST_DUMMY;
                            cnt_reg <= 5'h00;
                        end
                    end
                end
                sfdp_pkg::ST_DUMMY: begin
                    if (rise) begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == ((I_PROTO == sfdp_pkg::PR_QUAD) ?
                                `SFDP_DUMMY_QUAD : `SFDP_DUMMY_STD) - 5'h01) begin
                            st_reg <= sfdp_pkg::ST_DATA;
                            cnt_reg <= 5'h00;
                        end
                    end
                end
                sfdp_pkg::ST_DATA: begin
                    // cnt holds lane groups left in the current byte
                    if (fall) begin
                        cnt_reg <= (cnt_reg == 5'h00) ?
                            5'(5'h08 / 5'(addr_lanes(I_PROTO)) - 5'h01) :
                            cnt_reg - 5'h01;
                    end
                end
                sfdp_pkg::ST_IGNORE: st_reg <= sfdp_pkg::ST_IGNORE;
                default: st_reg <= sfdp_pkg::ST_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // table fetch into the fifo
    // -----------------------------------------------------------------
    // prefetch runs ahead of the shifter, stalled by a full fifo;
    // the pointer is 11 bits wide so it wraps at the table end by itself
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ptr_reg <= '0;
            fetch_reg <= 1'b0;
        end else if (cs_n) begin
            fetch_reg <= 1'b0;
        end else if (addr_done) begin
            ptr_reg <= addr_next[`SFDP_PTR_W-1:0];
            fetch_reg <= 1'b1;
        end else if (fetch_reg && fifo_ready) begin
            ptr_reg <= ptr_reg + 1'b1;
        end
    end

    assign rom_byte = table_byte(ptr_reg);

    sfdp_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(I_CLK),
        .rst(I_RST),
        .flush(cs_n),
        .in_valid(fetch_reg),
        .in_ready(fifo_ready),
        .in_data(rom_byte),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // -----------------------------------------------------------------
    // output shifter, changes on falling serial clock
    // -----------------------------------------------------------------
    assign pop = (st_reg == sfdp_pkg::ST_DATA) && fall && (cnt_reg == 5'h00);
    // an empty fifo cannot occur at sane clock ratios; fill byte guards it
    assign byte_now = fifo_valid ? fifo_data : `SFDP_FILL;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sh_reg <= 8'h00;
            drv_reg <= '0;
        end else if (cs_n || st_reg != sfdp_pkg::ST_DATA) begin
            drv_reg <= '0;
        end else if (fall) begin
            sh_reg <= pop ? byte_now << addr_lanes(I_PROTO) :
                sh_reg << addr_lanes(I_PROTO);
            drv_reg.value <= out_bits(I_PROTO, pop ? byte_now : sh_reg);
            case (I_PROTO)
                sfdp_pkg::PR_DUAL: drv_reg.oe <= 4'h3;
                sfdp_pkg::PR_QUAD: drv_reg.oe <= 4'hF;
                default: drv_reg.oe <= 4'h2;
            endcase
        end
    end

    assign O_DQ = drv_reg;
    assign O_ACTIVE = (st_reg != sfdp_pkg::ST_IDLE) && (st_reg != sfdp_pkg::ST_IGNORE);

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    quiet_dummy_a: assert property (st_reg == sfdp_pkg::ST_DUMMY |-> drv_reg.oe == 4'h0)
        else $error("lines driven during dummy clocks");
    dummy_len_a: assert property (st_reg == sfdp_pkg::ST_DUMMY && rise |=>
        (st_reg == sfdp_pkg::ST_DATA) ==
        ($past(cnt_reg) == (($past(I_PROTO) == sfdp_pkg::PR_QUAD) ? 5'h09 : 5'h07)))
        else $error("dummy length wrong");
    cs_release_a: assert property ($rose(cs_n) |=> drv_reg.oe == 4'h0 ##1
        st_reg == sfdp_pkg::ST_IDLE)
        else $error("lines not released after select high");
    start_addr_a: assert property (addr_done |=> ptr_reg == $past(addr_next[10:0]))
        else $error("start address not loaded");
    wrap_ptr_a: assert property (fetch_reg && fifo_ready && !cs_n && !addr_done &&
        ptr_reg == `SFDP_PTR_LAST |=> ptr_reg == 11'h000)
        else $error("pointer did not wrap");
    busy_skip_a: assert property (st_reg == sfdp_pkg::ST_CMD && rise && I_WRITE_BUSY &&
        cnt_reg == 5'h07 |=> st_reg != sfdp_pkg::ST_ADDR)
        else $error("command decoded while busy");
    sig_byte_a: assert property (ptr_reg == 11'h000 |-> rom_byte == 8'h53)
        else $error("signature byte wrong");
    hdr_len_a: assert property (ptr_reg == 11'h00B |-> rom_byte == 8'h09)
        else $error("header length wrong");
    fill_byte_a: assert property (ptr_reg inside {[11'h010:11'h02F]} |-> rom_byte == 8'hFF)
        else $error("fill byte wrong");
    erase_cfg_a: assert property (ptr_reg == 11'h030 |-> rom_byte[4:0] == 5'h05)
        else $error("erase config byte wrong");
    cover_data_c: cover property (st_reg == sfdp_pkg::ST_DUMMY ##1 st_reg == sfdp_pkg::ST_DATA);
    cover_wrap_c: cover property (ptr_reg == `SFDP_PTR_LAST ##[1:40] ptr_reg == 11'h000);
    cover_ignore_c: cover property (st_reg == sfdp_pkg::ST_IGNORE);
endmodule

// >>> core/empty_placeholder_removed.sv
`timescale 1ns/1ns

// >>> bench/sfdp_host_model.sv
// host controller model that clocks discovery table reads out of the responder
// assumes the bench resolves the data wires from the device's enables, else the host's level
`timescale 1ns/1ns

// ---------------------------------------------------------------
// serial host: command, address, dummy and data phases
// ---------------------------------------------------------------
module sfdp_host_model (
    // system clock and the device's drive
    input wire logic clk,
    input wire sfdp_pkg::drive_s dev,
    input wire logic [3:0] dq_in,
    // serial pins driven by the host
    output logic sck,
    output logic cs_n,
    output logic [3:0] dq_out
);
    int half = 10; // clk cycles per serial phase, 80 ns period at 10
    logic [7:0] got [$];
    logic [3:0] oe_data = 4'h0;
    logic [3:0] oe_quiet = 4'h0;
    logic quiet = 1'b0;
    logic rel = 1'b0;
    logic [3:0] dq_drv = 4'h0;
    logic [3:0] noise = 4'h0;

    // serial clock stands low and select high between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
    end

    // released lines wander every cycle so a stale value never passes
    always @(posedge clk) begin
        noise <= ~noise;
    end
    assign dq_out = rel ? noise : dq_drv;

    // any enable seen before data output is a fault
    always @(posedge clk) begin
        if (quiet) begin
            oe_quiet <= oe_quiet | dev.oe;
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one serial clock: set lines while low, sample late in the low phase
    task automatic bitclk(input logic [3:0] v, output logic [3:0] s, output logic [3:0] o);
        dq_drv <= v;
        wt(half - 1);
        @(negedge clk);
        s = dq_in;
        o = dev.oe;
        @(posedge clk);
        sck <= 1'b1;
        wt(half);
        sck <= 1'b0;
    endtask

    // whole frame; select rises after the last byte, ending the read
    task automatic frame(input logic [7:0] cmd, input logic [23:0] a,
                         input sfdp_pkg::proto_e pr, input int n);
        int w;
        logic [3:0] s;
        logic [3:0] o;
        logic [7:0] b;
        w = (pr == sfdp_pkg::PR_QUAD) ? 4 : (pr == sfdp_pkg::PR_DUAL) ? 2 : 1;
        got.delete();
        oe_quiet <= 4'h0;
        rel <= 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        quiet <= 1'b1;
        wt(half);
        for (int i = 0; i < 8; i++) begin
            bitclk({3'b000, cmd[7-i]}, s, o);
        end
        for (int i = 0; i < 24 / w; i++) begin
            bitclk(4'((a >> (24 - w * (i + 1))) & ((1 << w) - 1)), s, o);
        end
        rel <= 1'b1;
        for (int i = 0; i < ((pr == sfdp_pkg::PR_QUAD) ? 10 : 8); i++) begin
            bitclk(4'h0, s, o);
        end
        quiet <= 1'b0;
        for (int k = 0; k < n; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8 / w; j++) begin
                bitclk(4'h0, s, o);
                b = (b << w) | 8'((w == 1) ? {3'b000, s[1]} : (s & 4'((1 << w) - 1)));
                oe_data = o;
            end
            got.push_back(b);
        end
        wt(half);
        cs_n <= 1'b1;
    endtask
endmodule

// >>> bench/sfdp_parameter_read_tb.sv
// self-checking bench for the discovery table read responder
// assumes the host model file is compiled before this one
`timescale 1ns/1ns

// ---------------------------------------------------------------
// bench top
// ---------------------------------------------------------------
module sfdp_parameter_read_tb;
    localparam logic [7:0] CMD = 8'h5A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic busy = 1'b0;
    sfdp_pkg::proto_e proto = sfdp_pkg::PR_EXT;
    sfdp_pkg::drive_s dq_dev;
    logic sck;
    logic cs_n;
    logic active;
    logic [3:0] host_dq;
    logic [3:0] dq_wire;
    int failures = 0;
    int n_compared = 0;
    logic act_data = 1'b0;

    // 250 MHz system clock
    always #2 clk = ~clk;

    // each line shows whoever enables it, else the host's level
    assign dq_wire = (dq_dev.oe & dq_dev.value) | (~dq_dev.oe & host_dq);

    sfdp_parameter_read #(.CMD_CODE(CMD), .FIFO_DEPTH(8)) i_sfdp_parameter_read (
        .I_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_DQ(dq_wire),
        .O_DQ(dq_dev), .I_PROTO(proto), .I_WRITE_BUSY(busy), .O_ACTIVE(active));

    sfdp_host_model i_sfdp_host_model (
        .clk(clk), .dev(dq_dev), .dq_in(dq_wire), .sck(sck), .cs_n(cs_n), .dq_out(host_dq));

    // activity level last seen while the host clocks data out of the frame
    always @(posedge clk) begin
        if (!cs_n && !i_sfdp_host_model.quiet) begin
            act_data <= active;
        end
    end

    // expected table; bytes past 53h read as fill
    function automatic logic [7:0] exp_byte(input logic [10:0] a);
        logic [671:0] t;
        t = {128'h53464450_000100FF_00000109_300000FF, {32{8'hFF}},
             128'hE520F1FF_FFFFFF03_29EB276B_083B27BB,
             128'hFFFFFFFF_FFFF27BB_FFFF29EB_0C2010D8, 32'h00000000};
        return (a > 11'h053) ? 8'hFF : t[671 - 8 * int'(a) -: 8];
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one frame, then bytes, enables and release judged
    task automatic read_cmp(input logic [7:0] cmd, input logic [23:0] a,
                            input sfdp_pkg::proto_e pr, input int n, input logic [3:0] oe_exp);
        logic [10:0] p;
        proto <= pr;
        @(posedge clk);
        i_sfdp_host_model.frame(cmd, a, pr, n);
        for (int i = 0; i < n; i++) begin
            p = a[10:0] + 11'(i);
            if (oe_exp != 4'h0) begin
                check($sformatf("byte %h", p), i_sfdp_host_model.got[i], exp_byte(p));
            end
        end
        check("data enables", {4'h0, i_sfdp_host_model.oe_data}, {4'h0, oe_exp});
        check("quiet enables", {4'h0, i_sfdp_host_model.oe_quiet}, 8'h00);
        check("active in data", {7'h00, act_data}, {7'h00, oe_exp != 4'h0});
        repeat (6) @(posedge clk);
        check("released enables", {4'h0, dq_dev.oe}, 8'h00);
        check("active after frame", {7'h00, active}, 8'h00);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_header();
        read_cmp(CMD, 24'h000000, sfdp_pkg::PR_EXT, 16, 4'b0010);
    endtask

    task automatic t_fill();
        read_cmp(CMD, 24'h000010, sfdp_pkg::PR_DUAL, 32, 4'b0011);
    endtask

    // quad needs ten dummies; runs past 53h into fill
    task automatic t_params();
        read_cmp(CMD, 24'h000030, sfdp_pkg::PR_QUAD, 40, 4'b1111);
        read_cmp(CMD, 24'h000038, sfdp_pkg::PR_EXT, 28, 4'b0010);
        read_cmp(CMD, 24'h000040, sfdp_pkg::PR_DUAL, 20, 4'b0011);
    endtask

    // end of space folds back to the signature, no burst wrap applied
    task automatic t_wrap();
        read_cmp(CMD, 24'h0007FC, sfdp_pkg::PR_EXT, 8, 4'b0010);
    endtask

    // short read, then a fresh frame must start from its own address
    task automatic t_abort();
        read_cmp(CMD, 24'h00004C, sfdp_pkg::PR_DUAL, 1, 4'b0011);
        read_cmp(CMD, 24'h000002, sfdp_pkg::PR_EXT, 2, 4'b0010);
    endtask

    // foreign code and busy frames stay silent; then a slow host reads
    task automatic t_refuse();
        read_cmp(8'hA5, 24'h000000, sfdp_pkg::PR_EXT, 2, 4'h0);
        busy <= 1'b1;
        read_cmp(CMD, 24'h000000, sfdp_pkg::PR_QUAD, 2, 4'h0);
        busy <= 1'b0;
        i_sfdp_host_model.half = 25;
        read_cmp(CMD, 24'h000005, sfdp_pkg::PR_DUAL, 3, 4'b0011);
        i_sfdp_host_model.half = 10;
    endtask

    // main sequence after a 4-cycle reset
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_header();
        t_fill();
        t_params();
        t_wrap();
        t_abort();
        t_refuse();
        results();
    end

    // about two and a half times the expected run of some 24000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        results();
    end
endmodule
